// *** rtl/sfc_pkg.sv ***
// Shared constants and types for the surveillance flag command handler
package sfc_pkg;
	typedef enum logic [2:0] {
		TAG_READY,
		TAG_ARBITRATE,
		TAG_REPLY,
		TAG_ACKNOWLEDGED,
		TAG_OPEN,
		TAG_SECURED,
		TAG_KILLED
	} sfc_tag_state_e;
	localparam logic [15:0] FLAG_WRITE_CODE = 16'he003;
	localparam logic [15:0] ALARM_CODE = 16'he004;
	localparam logic [15:0] ALARM_CODE_INV = 16'h1ffb;
	localparam logic [15:0] CRC16_PRESET = 16'hffff;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [15:0] CRC16_RESIDUE = 16'h1d0f;
	localparam logic [4:0] CRC5_PRESET = 5'h09;
	localparam int FLAG_WRITE_BITS = 49;
	localparam int ALARM_BITS = 52;
	localparam int FRAME_BITS = 68;
	localparam int FLAG_REPLY_BITS = 33;
	localparam int ALARM_REPLY_BITS = 65;
	localparam int REPLY_TIMEOUT_MS = 20;
	localparam int CLK_MHZ = 125;
	localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] ERR_CODE = 8'h0f;
	localparam int ERR_REPLY_BITS = 41;
	localparam logic [1:0] DIV_8 = 2'h0;
	localparam logic [1:0] DIV_64_3 = 2'h1;
endpackage

// *** rtl/sfc_link_if.sv ***
// Air link between interrogator logic and tag command handler
`timescale 1ns/1ps
interface sfc_link_if;
	logic cmdBit;
	logic cmdValid;
	logic cmdEnd;
	logic frameSyncOnly;
	logic rspBit;
	logic rspValid;
	logic rspStart;
	logic rspEnd;
	logic rspPilot;
	logic rspDivRatio;
	logic [1:0] rspCyclesPerSym;
	logic cwOn;
	modport tag (input cmdBit, cmdValid, cmdEnd, frameSyncOnly, cwOn,
		output rspBit, rspValid, rspStart, rspEnd, rspPilot, rspDivRatio, rspCyclesPerSym);
	modport reader (output cmdBit, cmdValid, cmdEnd, frameSyncOnly, cwOn,
		input rspBit, rspValid, rspStart, rspEnd, rspPilot, rspDivRatio, rspCyclesPerSym);
endinterface

// *** rtl/sfc_tag_end.sv ***
// Tag end: flag write and fast alarm command handler
//
// How it works
// - Flag write only accepted when secured
// - Zero access password ignores flag write
// - Bad CRC or handle: ignore, stay
// - Flag write frame: code, value, handle, CRC
// - Reader sends frame-sync before flag write
// - Value bit sets or clears flag
// - Reply zero header, handle, CRC-16
// - Flag write reply always with pilot
// - Reader holds CW up to 20 ms
// - Execution error sends error code instead
// - Reader may check presence and resend
// - Alarm works after power-up with flag
// - Alarm frame: code, inverse, DR, M, TRext, CRC
// - DR bit picks divide ratio
// - M field picks cycles per symbol
// - TRext bit picks pilot tone
// - Reader sends full preamble before alarm
// - Alarm answered only ready with flag
// - CRC5 preset, zero header, 64-bit code
// - Alarm reply needs no prior inventory
//
// The implementer's own choices: the plain strobed port.
`timescale 1ns/1ps
module sfc_tag_end #(
	parameter logic [63:0] ALARM_VALUE = 64'h0123456789abcdef
) (
	input wire logic core_clk,
	input wire logic nrst,
	sfc_link_if.tag link,
	input wire sfc_pkg::sfc_tag_state_e tagState,
	input wire logic [31:0] accessPassword,
	input wire logic [15:0] handle,
	input wire logic flagAtPowerUp,
	input wire logic writeError,
	output sfc_pkg::sfc_tag_state_e nextState,
	output logic nextStateValid,
	output logic theftAlarmFlag,
	output logic alarmArmed
);
	logic [67:0] shift_q;
	logic [6:0] count_q;
	logic [15:0] crc_q;
	logic [15:0] crcNext;
	logic [64:0] reply_q;
	logic [6:0] replyLeft_q;
	logic [15:0] rcrc_q;
	logic rcrcPhase_q;
	logic [4:0] crc5_q;
	logic flag_q;
	logic armed_q;
	logic started_q;
	logic active_q;
	logic first_q;
	logic pilot_q;
	logic divr_q;
	logic [1:0] mSel_q;
	sfc_pkg::sfc_tag_state_e nextState_q;
	logic nextValid_q;
	logic fbIn;
	logic rfb;
	logic [15:0] rcrcNext;

	// Registers must hold the longest frame and reply
	if (sfc_pkg::FRAME_BITS < sfc_pkg::ALARM_BITS
		|| sfc_pkg::ALARM_REPLY_BITS > 65) begin : g_bad_sizes
		$error("Frame or reply longer than its register");
	end

	assign fbIn = crc_q[15] ^ link.cmdBit;
	assign crcNext = {crc_q[14:0], 1'b0} ^ (fbIn ? sfc_pkg::CRC16_POLY : 16'h0000);
	assign rfb = rcrc_q[15] ^ reply_q[64];
	assign rcrcNext = {rcrc_q[14:0], 1'b0} ^ (rfb ? sfc_pkg::CRC16_POLY : 16'h0000);

	wire crcOk = (crc_q == sfc_pkg::CRC16_RESIDUE);
	wire isFlagWrite = (count_q == 7'(sfc_pkg::FLAG_WRITE_BITS))
		&& (shift_q[48:33] == sfc_pkg::FLAG_WRITE_CODE);
	wire isAlarm = (count_q == 7'(sfc_pkg::ALARM_BITS))
		&& (shift_q[51:36] == sfc_pkg::ALARM_CODE) && (shift_q[35:20] == sfc_pkg::ALARM_CODE_INV);
	wire valueBit = shift_q[32];
	wire handleOk = (shift_q[31:16] == handle);
	wire pwZero = (accessPassword == 32'h0000_0000);
	wire inArb = (tagState == sfc_pkg::TAG_ARBITRATE) || (tagState == sfc_pkg::TAG_REPLY)
		|| (tagState == sfc_pkg::TAG_ACKNOWLEDGED);
	wire fwAccept = link.cmdEnd && isFlagWrite && crcOk && handleOk && !pwZero
		&& (tagState == sfc_pkg::TAG_SECURED) && link.frameSyncOnly;
	wire alAccept = link.cmdEnd && isAlarm && crcOk && armed_q
		&& (tagState == sfc_pkg::TAG_READY) && !link.frameSyncOnly;
	wire toArb = link.cmdEnd && (isFlagWrite || isAlarm) && crcOk && inArb;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shift_q <= '0;
			count_q <= '0;
			crc_q <= sfc_pkg::CRC16_PRESET;
		end else if (link.cmdEnd) begin
			count_q <= '0;
			crc_q <= sfc_pkg::CRC16_PRESET;
		end else if (link.cmdValid) begin
			shift_q <= {shift_q[66:0], link.cmdBit};
			if (count_q != 7'(sfc_pkg::FRAME_BITS))
				count_q <= count_q + 7'd1;
			crc_q <= crcNext;
		end
	end

	// flag captured as armed at power-up
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			started_q <= 1'b0;
			armed_q <= 1'b0;
			flag_q <= 1'b0;
		end else if (!started_q) begin
			started_q <= 1'b1;
			armed_q <= flagAtPowerUp;
			flag_q <= flagAtPowerUp;
		end else if (fwAccept && !writeError) begin
			flag_q <= valueBit;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			nextState_q <= sfc_pkg::TAG_READY;
			nextValid_q <= 1'b0;
		end else begin
			nextValid_q <= toArb || fwAccept || alAccept;
			nextState_q <= toArb ? sfc_pkg::TAG_ARBITRATE : tagState;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reply_q <= '0;
			replyLeft_q <= '0;
			rcrc_q <= '0;
			rcrcPhase_q <= 1'b0;
			crc5_q <= '0;
			active_q <= 1'b0;
			first_q <= 1'b0;
			pilot_q <= 1'b0;
			divr_q <= 1'b0;
			mSel_q <= 2'h0;
		end else if (fwAccept && link.cwOn) begin
			active_q <= 1'b1;
			first_q <= 1'b1;
			pilot_q <= 1'b1;
			rcrc_q <= sfc_pkg::CRC16_PRESET;
			if (writeError) begin
				reply_q <= {1'b1, sfc_pkg::ERR_CODE, handle, 40'h0};
				replyLeft_q <= 7'(sfc_pkg::ERR_REPLY_BITS - 16);
			end else begin
				reply_q <= {1'b0, handle, 48'h0};
				replyLeft_q <= 7'(sfc_pkg::FLAG_REPLY_BITS - 16);
			end
			rcrcPhase_q <= 1'b1;
		end else if (alAccept) begin
			active_q <= 1'b1;
			first_q <= 1'b1;
			divr_q <= shift_q[19];
			mSel_q <= shift_q[18:17];
			pilot_q <= shift_q[16];
			crc5_q <= sfc_pkg::CRC5_PRESET;
			reply_q <= {1'b0, ALARM_VALUE};
			replyLeft_q <= 7'(sfc_pkg::ALARM_REPLY_BITS);
			rcrcPhase_q <= 1'b0;
		end else if (active_q) begin
			first_q <= 1'b0;
			if (replyLeft_q == 7'd1 && rcrcPhase_q) begin
				reply_q <= {~rcrcNext, 49'h0};
				replyLeft_q <= 7'd16;
				rcrcPhase_q <= 1'b0;
			end else if (replyLeft_q == 7'd1) begin
				active_q <= 1'b0;
				replyLeft_q <= '0;
			end else begin
				reply_q <= {reply_q[63:0], 1'b0};
				replyLeft_q <= replyLeft_q - 7'd1;
			end
			if (rcrcPhase_q)
				rcrc_q <= rcrcNext;
		end
	end

	wire started = first_q && (rcrcPhase_q || crc5_q == sfc_pkg::CRC5_PRESET);
	assign link.rspBit = reply_q[64];
	assign link.rspValid = active_q;
	assign link.rspStart = started;
	assign link.rspEnd = active_q && replyLeft_q == 7'd1 && !rcrcPhase_q;
	assign link.rspPilot = pilot_q;
	assign link.rspDivRatio = divr_q;
	assign link.rspCyclesPerSym = mSel_q;
	assign nextState = nextState_q;
	assign nextStateValid = nextValid_q;
	assign theftAlarmFlag = flag_q;
	assign alarmArmed = armed_q;
endmodule

// *** rtl/sfc_reader_end.sv ***
// Reader end: frames the two commands and collects the reply
`timescale 1ns/1ps
module sfc_reader_end #(
	parameter int TIMEOUT_CYC = sfc_pkg::REPLY_TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	sfc_link_if.reader link,
	input wire logic sendFlagWrite,
	input wire logic sendAlarm,
	input wire logic flagValue,
	input wire logic [15:0] handle,
	input wire logic divRatio,
	input wire logic [1:0] cyclesPerSym,
	input wire logic pilotReq,
	output logic busy,
	output logic done,
	output logic timedOut,
	output logic [64:0] rxData
);
	if (TIMEOUT_CYC < 1) begin : g_bad_timeout
		$error("TIMEOUT_CYC must be positive");
	end
	logic [67:0] frame_q;
	logic [6:0] left_q;
	logic [15:0] crc_q;
	logic [6:0] crcLeft_q;
	logic waitRsp_q;
	logic sync_q;
	logic [31:0] timer_q;
	logic done_q;
	logic tout_q;
	logic [64:0] rx_q;
	wire fb = crc_q[15] ^ frame_q[67];
	wire [15:0] crcNext = {crc_q[14:0], 1'b0} ^ (fb ? sfc_pkg::CRC16_POLY : 16'h0000);
	wire sending = (left_q != 7'd0);
	wire idle = !sending && !waitRsp_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			frame_q <= '0;
			left_q <= '0;
			crc_q <= sfc_pkg::CRC16_PRESET;
			crcLeft_q <= '0;
			sync_q <= 1'b0;
			waitRsp_q <= 1'b0;
			timer_q <= '0;
			done_q <= 1'b0;
			tout_q <= 1'b0;
			rx_q <= '0;
		end else begin
			done_q <= 1'b0;
			tout_q <= 1'b0;
			if (idle && sendFlagWrite) begin
				frame_q <= {sfc_pkg::FLAG_WRITE_CODE, flagValue, handle, 35'h0};
				left_q <= 7'(sfc_pkg::FLAG_WRITE_BITS);
				crcLeft_q <= 7'd33;
				sync_q <= 1'b1;
				crc_q <= sfc_pkg::CRC16_PRESET;
			end else if (idle && sendAlarm) begin
				frame_q <= {sfc_pkg::ALARM_CODE, sfc_pkg::ALARM_CODE_INV, divRatio, cyclesPerSym,
					pilotReq, 32'h0};
				left_q <= 7'(sfc_pkg::ALARM_BITS);
				crcLeft_q <= 7'd36;
				sync_q <= 1'b0;
				crc_q <= sfc_pkg::CRC16_PRESET;
			end else if (sending) begin
				if (crcLeft_q == 7'd1)
					frame_q <= {~crcNext, 52'h0};
				else
					frame_q <= {frame_q[66:0], 1'b0};
				if (crcLeft_q != 7'd0) begin
					crc_q <= crcNext;
					crcLeft_q <= crcLeft_q - 7'd1;
				end
				left_q <= left_q - 7'd1;
				if (left_q == 7'd1) begin
					waitRsp_q <= 1'b1;
					timer_q <= '0;
				end
			end else if (waitRsp_q) begin
				// CW held until reply or timeout
				if (link.rspValid) begin
					rx_q <= {rx_q[63:0], link.rspBit};
					timer_q <= '0;
					if (link.rspEnd) begin
						waitRsp_q <= 1'b0;
						done_q <= 1'b1;
					end
				end else if (timer_q == 32'(TIMEOUT_CYC - 1)) begin
					waitRsp_q <= 1'b0;
					tout_q <= 1'b1;
				end else begin
					timer_q <= timer_q + 32'd1;
				end
			end
		end
	end

	assign link.cmdBit = frame_q[67];
	assign link.cmdValid = sending;
	assign link.cmdEnd = waitRsp_q && timer_q == 32'd0 && !link.rspValid && !done_q;
	assign link.frameSyncOnly = sync_q;
	assign link.cwOn = waitRsp_q;
	assign busy = !idle;
	assign done = done_q;
	assign timedOut = tout_q;
	assign rxData = rx_q;
endmodule

// *** dv/sfc_props.sv ***
// Link checker for the flag write and alarm exchanges
`timescale 1ns/1ps
module sfc_props (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cmdValid,
	input wire logic cmdEnd,
	input wire logic frameSyncOnly,
	input wire logic cwOn,
	input wire logic rspBit,
	input wire logic rspValid,
	input wire logic rspStart,
	input wire logic rspEnd,
	input wire logic rspPilot
);
	logic [6:0] cmdCnt_q, cmdCnt_d, rspCnt_q, rspCnt_d;
	logic fs_q, fs_d;
	assign cmdCnt_d = cmdEnd ? 7'h0 : cmdCnt_q + {6'h0, cmdValid};
	assign rspCnt_d = rspStart ? 7'h1 : rspCnt_q + {6'h0, rspValid};
	assign fs_d = cmdEnd ? frameSyncOnly : fs_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cmdCnt_q <= 7'h0;
			rspCnt_q <= 7'h0;
			fs_q <= 1'b0;
		end else begin
			cmdCnt_q <= cmdCnt_d;
			rspCnt_q <= rspCnt_d;
			fs_q <= fs_d;
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	a_fw_frame_len: assert property (cmdEnd && frameSyncOnly |-> cmdCnt_q == 7'h31)
		else $error("flag write frame length");
	a_alarm_frame_len: assert property (cmdEnd && !frameSyncOnly |-> cmdCnt_q == 7'h34)
		else $error("alarm frame length");
	a_frame_end_mark: assert property ($fell(cmdValid) |-> cmdEnd)
		else $error("frame end missing");
	a_fw_pilot_on: assert property (cmdEnd && frameSyncOnly ##1 rspStart |-> rspPilot)
		else $error("flag reply without pilot");
	a_alarm_header_zero: assert property (cmdEnd && !frameSyncOnly ##1 rspStart |-> !rspBit)
		else $error("alarm header");
	a_alarm_prompt: assert property (rspStart && !fs_q |-> $past(cmdEnd))
		else $error("alarm reply late");
	a_alarm_rsp_len: assert property (rspEnd && !fs_q |-> rspCnt_q == 7'h40)
		else $error("alarm reply length");
	a_fw_rsp_len: assert property (rspEnd && fs_q
		|-> rspCnt_q == 7'h20 || rspCnt_q == 7'h28)
		else $error("flag reply length");
	a_reply_under_cw: assert property (rspValid |-> cwOn)
		else $error("reply without carrier");
	c_fw: cover property (rspEnd && fs_q);
	c_alarm: cover property (rspEnd && !fs_q);
	c_refused: cover property ($fell(cwOn) && !rspValid);
endmodule

// *** dv/tb_surveillance_flag_cmd_handler.sv ***
// Self-checking bench joining reader end and tag end
`timescale 1ns/1ps
module tb_surveillance_flag_cmd_handler;
	localparam logic [63:0] AV = 64'h5a5a0f0f3c3c9669;
	logic core_clk, nrst, flagAtPowerUp, writeError, sendFlagWrite, sendAlarm, flagValue;
	logic divRatio, pilotReq, done, timedOut, nextStateValid, theftAlarmFlag, alarmArmed;
	logic acc, flagExp, busy, sawValid, arbSt;
	logic [1:0] cyclesPerSym;
	logic [15:0] tagHandle, rdHandle;
	logic [31:0] accessPassword, r, q;
	logic [64:0] rxData;
	sfc_pkg::sfc_tag_state_e tagState, nextState, st, seenNext;
	int err_total, total_checks, seed;
	sfc_link_if link();
	sfc_tag_end #(.ALARM_VALUE(AV)) sfc_tag_end_inst(.core_clk(core_clk), .nrst(nrst),
		.link(link.tag), .tagState(tagState), .accessPassword(accessPassword),
		.handle(tagHandle), .flagAtPowerUp(flagAtPowerUp), .writeError(writeError),
		.nextState(nextState), .nextStateValid(nextStateValid),
		.theftAlarmFlag(theftAlarmFlag), .alarmArmed(alarmArmed));
	sfc_reader_end #(.TIMEOUT_CYC(200)) sfc_reader_end_inst(.core_clk(core_clk), .nrst(nrst),
		.link(link.reader), .sendFlagWrite(sendFlagWrite), .sendAlarm(sendAlarm),
		.flagValue(flagValue), .handle(rdHandle), .divRatio(divRatio),
		.cyclesPerSym(cyclesPerSym), .pilotReq(pilotReq), .busy(busy), .done(done),
		.timedOut(timedOut), .rxData(rxData));
	sfc_props sfc_props_inst(.core_clk(core_clk), .nrst(nrst), .cmdValid(link.cmdValid),
		.cmdEnd(link.cmdEnd), .frameSyncOnly(link.frameSyncOnly), .cwOn(link.cwOn),
		.rspBit(link.rspBit), .rspValid(link.rspValid), .rspStart(link.rspStart),
		.rspEnd(link.rspEnd), .rspPilot(link.rspPilot));
	task automatic chk(input logic [64:0] seen, input logic [64:0] exp, input string nm);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [15:0] crc16(input logic [16:0] d);
		logic [15:0] c;
		c = 16'hffff;
		for (int k = 16; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0);
		return ~c;
	endfunction
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		end_of_test();
	end
	initial begin
		seed = 32'h565c;
		{sendFlagWrite, sendAlarm, flagValue, divRatio, pilotReq, writeError} = 6'h0;
		{cyclesPerSym, tagHandle, rdHandle, accessPassword} = 66'h0;
		tagState = sfc_pkg::TAG_READY;
		for (int p = 0; p < 2; p++) begin
			nrst <= 1'b0;
			flagAtPowerUp <= p[0];
			repeat (6) @(posedge core_clk);
			nrst <= 1'b1;
			repeat (2) @(posedge core_clk);
			flagExp = p[0];
			for (int i = 0; i < 30; i++) begin
				@(posedge core_clk);
				r = $random(seed);
				q = $random(seed);
				st = sfc_pkg::sfc_tag_state_e'(q[2:0] % 3'h7);
				if (q[3])
					st = r[0] ? sfc_pkg::TAG_READY : sfc_pkg::TAG_SECURED;
				if (i < 4) begin
					st = sfc_pkg::TAG_READY;
					r[0] = 1'b1;
					q[5:4] = i[1:0];
				end
				if (i == 4 || i == 5) begin
					st = sfc_pkg::TAG_SECURED;
					r[0] = 1'b0;
					{r[8], r[7:5], r[4], r[2]} = {1'b1, {3{i == 4}}, 2'h0};
				end
				tagState <= st;
				accessPassword <= (r[1] & r[2]) ? 32'h0 : (q | 32'h1);
				rdHandle <= r[31:16];
				tagHandle <= r[31:16] ^ {15'h0, r[3] & r[4]};
				writeError <= r[5] & r[6] & r[7];
				{flagValue, divRatio, pilotReq, cyclesPerSym} <= {r[8], r[9], r[10], q[5:4]};
				sendAlarm <= r[0];
				sendFlagWrite <= !r[0];
				@(posedge core_clk);
				sendAlarm <= 1'b0;
				sendFlagWrite <= 1'b0;
				@(negedge core_clk);
				chk(busy, 1'b1, "busy");
				sawValid = 1'b0;
				seenNext = st;
				for (int n = 0; n < 500 && done !== 1'b1 && timedOut !== 1'b1; n++) begin
					@(negedge core_clk);
					if (nextStateValid === 1'b1) begin
						seenNext = nextState;
						sawValid = 1'b1;
					end
				end
				acc = r[0] ? (st == sfc_pkg::TAG_READY && p == 1) : (st == sfc_pkg::TAG_SECURED
					&& !(r[1] & r[2]) && !(r[3] & r[4]));
				chk(done, acc, "reply");
				chk(timedOut, !acc, "timeout");
				arbSt = st inside {sfc_pkg::TAG_ARBITRATE, sfc_pkg::TAG_REPLY,
					sfc_pkg::TAG_ACKNOWLEDGED};
				chk(seenNext, arbSt ? sfc_pkg::TAG_ARBITRATE : st, "next state");
				chk(sawValid, arbSt || acc, "next valid");
				chk(busy, 1'b0, "idle");
				if (acc && r[0]) begin
					chk(rxData, {1'b0, AV}, "alarm code");
					chk({link.rspDivRatio, link.rspCyclesPerSym, link.rspPilot},
						{r[9], q[5:4], r[10]}, "link setup");
				end else if (acc && (r[5] & r[6] & r[7])) begin
					chk(rxData[40:32], {1'b1, 8'h0f}, "error reply");
				end else if (acc) begin
					flagExp = r[8];
					chk(rxData[32:0], {1'b0, r[31:16], crc16({1'b0, r[31:16]})}, "handle");
					chk(link.rspPilot, 1'b1, "pilot");
				end
				chk(theftAlarmFlag, flagExp, "flag");
				chk(alarmArmed, p[0], "armed");
			end
			@(posedge core_clk);
		end
		end_of_test();
	end
endmodule
